// ---- shared/dcf_pkg.sv ----
// Operation
// RQ1 - Store 8192 words of nine bits
// RQ2 - Capture input word on qualified write edge
// RQ3 - Reset clears pointers, sets flag levels
// RQ4 - Controller resets buffer before first write
// RQ5 - Reset level selects dual enable or load
// RQ6 - Load mode: primary enable alone writes
// RQ7 - Dual mode: primary low, second high writes
// RQ8 - Writes ignored while full flag low
// RQ9 - Controller holds load low for offsets
// RQ10 - Pop word when both read enables active
// RQ11 - Tied or independent read clock works
// RQ12 - Default thresholds empty+7 and full-7
// RQ13 - Small state machine sequences offset loading
// RQ14 - Output enable tristates the data bus
// RQ15 - Reads ignored while empty; enables active low
// RQ16 - Full flags follow the write clock
// RQ17 - Empty flags follow the read clock
// RQ18 - Pointer crossing never shows phantom space/data
package dcf_pkg;
	localparam int unsigned DEPTH       = 8192;
	localparam int unsigned DATA_W      = 9;
	localparam int unsigned ADDR_W      = 13;
	localparam int unsigned OFS_HI_W    = ADDR_W - DATA_W;
	localparam logic [ADDR_W-1:0] AE_OFS_RESET = 13'h0007;
	localparam logic [ADDR_W-1:0] AF_OFS_RESET = 13'h0007;
	localparam logic MODE_DUAL_WE = 1'h1;
	localparam logic MODE_PROG    = 1'h0;

	typedef enum logic [1:0] {
		OFS_AE_LO = 2'h0,
		OFS_AE_HI = 2'h1,
		OFS_AF_LO = 2'h3,
		OFS_AF_HI = 2'h2
	} dcf_ofs_state_t;

	typedef struct packed {
		logic emptyN;
		logic almostEmptyN;
		logic almostFullN;
		logic fullN;
	} dcf_flags_t;

	localparam dcf_flags_t FLAGS_RESET = '{emptyN: 1'b0, almostEmptyN: 1'b0, almostFullN: 1'b1, fullN: 1'b1};
endpackage : dcf_pkg

// ---- src/dcf_fifo.sv ----
module dcf_fifo #(
	parameter int unsigned DEPTH  = dcf_pkg::DEPTH,
	parameter int unsigned DATA_W = dcf_pkg::DATA_W,
	parameter int unsigned ADDR_W = dcf_pkg::ADDR_W
) (
	input  wire logic              clk,
	input  wire logic              rstn,
	input  wire logic              writeClockEdge,
	input  wire logic              readClockEdge,
	input  wire logic [DATA_W-1:0] dataIn,
	input  wire logic              primaryWriteEnable_n,
	input  wire logic              secondEnableOrLoadPin,
	input  wire logic              readEnableA_n,
	input  wire logic              readEnableB_n,
	input  wire logic              outputEnable_n,
	output logic [DATA_W-1:0]      dataOut,
	output logic                   dataOutEn,
	output logic                   emptyFlag_n,
	output logic                   almostEmptyFlag_n,
	output logic                   almostFullFlag_n,
	output logic                   fullFlag_n,
	output logic                   dualWriteMode
);

	////////////////////////////////////////////////////////////////////////////////
	// Storage and pointers
	// Pointers carry one extra wrap bit so full and empty differ
	localparam int unsigned PTR_W = ADDR_W + 1;
	localparam logic [PTR_W-1:0] DEPTH_P = PTR_W'(DEPTH);
	// Offsets are held as two bus words and masked to the address width,
	// so a shallow build needs no special slicing
	localparam int unsigned      OFS_W    = 2 * DATA_W;
	localparam logic [OFS_W-1:0] OFS_MASK = OFS_W'((64'h1 << ADDR_W) - 64'h1);

	logic [DATA_W-1:0] mem [DEPTH]; // [RQ1]
	logic [PTR_W-1:0]  wrPtr_q;
	logic [PTR_W-1:0]  wrPtr_d;
	logic [PTR_W-1:0]  rdPtr_q;
	logic [PTR_W-1:0]  rdPtr_d;
	logic              modeDual_q;
	logic              modeDual_d;
	logic              cfgDone_q;
	logic              cfgDone_d;
	logic [OFS_W-1:0]  aeOfs_q;
	logic [OFS_W-1:0]  aeOfs_d;
	logic [OFS_W-1:0]  afOfs_q;
	logic [OFS_W-1:0]  afOfs_d;
	dcf_pkg::dcf_ofs_state_t ofsState_q;
	dcf_pkg::dcf_ofs_state_t ofsState_d;
	dcf_pkg::dcf_flags_t     flags_q;
	dcf_pkg::dcf_flags_t     flags_d;
	logic [DATA_W-1:0] dataOut_q;
	logic [DATA_W-1:0] dataOut_d;

	logic              loadActive;
	logic              writeQual;
	logic              doWrite;
	logic              readQual;
	logic              doRead;
	logic              ofsWrite;
	logic              ofsRead;
	logic [PTR_W-1:0]  count;

	////////////////////////////////////////////////////////////////////////////////
	// Configuration capture
	// The pin level is latched on the first edge after reset release, so
	// the async reset itself only ever loads constants
	always_comb begin
		modeDual_d = modeDual_q;
		cfgDone_d  = 1'b1;
		if (!cfgDone_q) begin
			modeDual_d = secondEnableOrLoadPin; // [RQ5]
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			modeDual_q <= dcf_pkg::MODE_DUAL_WE;
			cfgDone_q  <= 1'b0;
		end else begin
			modeDual_q <= modeDual_d;
			cfgDone_q  <= cfgDone_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Request decode
	// One clock only: write and read clock edges arrive as enable pulses,
	// so tied or independent clocks need no crossing and no pointer can be stale
	assign loadActive = !modeDual_q && !secondEnableOrLoadPin; // [RQ9]

	always_comb begin
		if (modeDual_q == dcf_pkg::MODE_DUAL_WE) begin
			writeQual = !primaryWriteEnable_n && secondEnableOrLoadPin; // [RQ7]
		end else begin
			writeQual = !primaryWriteEnable_n && !loadActive; // [RQ6]
		end
	end

	assign doWrite  = cfgDone_q && writeClockEdge && writeQual && flags_q.fullN; // [RQ2] [RQ8]
	assign readQual = !readEnableA_n && !readEnableB_n; // [RQ15]
	assign doRead   = cfgDone_q && readClockEdge && readQual && !loadActive && flags_q.emptyN; // [RQ10] [RQ15] [RQ11]
	assign ofsWrite = cfgDone_q && writeClockEdge && loadActive && !primaryWriteEnable_n;
	assign ofsRead  = cfgDone_q && readClockEdge && loadActive && readQual;

	////////////////////////////////////////////////////////////////////////////////
	// Pointers and storage
	always_comb begin
		wrPtr_d = wrPtr_q;
		rdPtr_d = rdPtr_q;
		if (doWrite) begin
			wrPtr_d = wrPtr_q + PTR_W'(1);
		end
		if (doRead) begin
			rdPtr_d = rdPtr_q + PTR_W'(1);
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wrPtr_q <= '0; // [RQ3]
			rdPtr_q <= '0; // [RQ3]
		end else begin
			wrPtr_q <= wrPtr_d;
			rdPtr_q <= rdPtr_d;
		end
	end

	// Storage is not reset: contents are meaningless until written
	always_ff @(posedge clk) begin
		if (doWrite) begin
			mem[wrPtr_q[ADDR_W-1:0]] <= dataIn; // [RQ2]
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Offset load and read sequencer
	// Each offset takes two bus words: low nine bits, then the high bits.
	// Reads and writes share one sequence position, as in the pin device
	always_comb begin
		ofsState_d = ofsState_q;
		aeOfs_d    = aeOfs_q;
		afOfs_d    = afOfs_q;
		if (ofsWrite) begin
			case (ofsState_q)
				dcf_pkg::OFS_AE_LO: aeOfs_d = {aeOfs_q[OFS_W-1:DATA_W], dataIn} & OFS_MASK;
				dcf_pkg::OFS_AE_HI: aeOfs_d = {dataIn, aeOfs_q[DATA_W-1:0]} & OFS_MASK;
				dcf_pkg::OFS_AF_LO: afOfs_d = {afOfs_q[OFS_W-1:DATA_W], dataIn} & OFS_MASK;
				dcf_pkg::OFS_AF_HI: afOfs_d = {dataIn, afOfs_q[DATA_W-1:0]} & OFS_MASK;
				default:            aeOfs_d = aeOfs_q;
			endcase
		end
		if (ofsWrite || ofsRead) begin
			case (ofsState_q)
				dcf_pkg::OFS_AE_LO: ofsState_d = dcf_pkg::OFS_AE_HI; // [RQ13]
				dcf_pkg::OFS_AE_HI: ofsState_d = dcf_pkg::OFS_AF_LO;
				dcf_pkg::OFS_AF_LO: ofsState_d = dcf_pkg::OFS_AF_HI;
				dcf_pkg::OFS_AF_HI: ofsState_d = dcf_pkg::OFS_AE_LO;
				default:            ofsState_d = dcf_pkg::OFS_AE_LO;
			endcase
		end else if (!loadActive) begin
			ofsState_d = dcf_pkg::OFS_AE_LO; // Releasing load restarts the sequence
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ofsState_q <= dcf_pkg::OFS_AE_LO;
			aeOfs_q    <= OFS_W'(dcf_pkg::AE_OFS_RESET); // [RQ12]
			afOfs_q    <= OFS_W'(dcf_pkg::AF_OFS_RESET); // [RQ12]
		end else begin
			ofsState_q <= ofsState_d;
			aeOfs_q    <= aeOfs_d;
			afOfs_q    <= afOfs_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Flags
	// Flags are computed from the pointers after this edge's moves.
	// Full flags refresh only on write edges and empty flags only on read
	// edges; a stale flag can only look more full or more empty than true,
	// so it never admits a write or read that does not fit
	assign count = wrPtr_d - rdPtr_d;

	always_comb begin
		flags_d = flags_q;
		if (cfgDone_q && writeClockEdge) begin
			flags_d.fullN       = count != DEPTH_P; // [RQ16] [RQ18]
			flags_d.almostFullN = count < (DEPTH_P - PTR_W'(afOfs_q)); // [RQ16] [RQ12]
		end
		if (cfgDone_q && readClockEdge) begin
			flags_d.emptyN        = count != '0; // [RQ17] [RQ18]
			flags_d.almostEmptyN  = count > PTR_W'(aeOfs_q); // [RQ17] [RQ12]
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			flags_q <= dcf_pkg::FLAGS_RESET; // [RQ3]
		end else begin
			flags_q <= flags_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Output data
	// Popped word, or offset readback while load is held in flag mode
	always_comb begin
		dataOut_d = dataOut_q;
		if (doRead) begin
			dataOut_d = mem[rdPtr_q[ADDR_W-1:0]]; // [RQ10]
		end else if (ofsRead) begin
			case (ofsState_q)
				dcf_pkg::OFS_AE_LO: dataOut_d = aeOfs_q[DATA_W-1:0];
				dcf_pkg::OFS_AE_HI: dataOut_d = aeOfs_q[OFS_W-1:DATA_W];
				dcf_pkg::OFS_AF_LO: dataOut_d = afOfs_q[DATA_W-1:0];
				dcf_pkg::OFS_AF_HI: dataOut_d = afOfs_q[OFS_W-1:DATA_W];
				default:            dataOut_d = dataOut_q;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			dataOut_q <= '0;
		end else begin
			dataOut_q <= dataOut_d;
		end
	end

	assign dataOut           = dataOut_q;
	assign dataOutEn         = !outputEnable_n; // [RQ14]
	assign emptyFlag_n       = flags_q.emptyN;
	assign almostEmptyFlag_n = flags_q.almostEmptyN;
	assign almostFullFlag_n  = flags_q.almostFullN;
	assign fullFlag_n        = flags_q.fullN;
	assign dualWriteMode     = modeDual_q;

endmodule : dcf_fifo

// ---- tb/dcf_fifo_monitor.sv ----
module dcf_fifo_monitor #(
	parameter int unsigned DATA_W = 9
) (
	input wire logic              clk,
	input wire logic              rstn,
	input wire logic              writeClockEdge,
	input wire logic              readClockEdge,
	input wire logic              secondEnableOrLoadPin,
	input wire logic              readEnableA_n,
	input wire logic              readEnableB_n,
	input wire logic              outputEnable_n,
	input wire logic [DATA_W-1:0] dataOut,
	input wire logic              dataOutEn,
	input wire logic              emptyFlag_n,
	input wire logic              almostEmptyFlag_n,
	input wire logic              almostFullFlag_n,
	input wire logic              fullFlag_n,
	input wire logic              dualWriteMode
);
	timeunit 1ns;
	timeprecision 1ns;
	// A pop since the last write edge lets the next write edge raise the full flag
	logic popNow;
	logic popSince_q;
	logic popSince_d;
	assign popNow = readClockEdge && !readEnableA_n && !readEnableB_n && emptyFlag_n
		&& (dualWriteMode || secondEnableOrLoadPin);
	always_comb begin
		popSince_d = popNow || (popSince_q && !writeClockEdge);
	end
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			popSince_q <= 1'b0;
		end else begin
			popSince_q <= popSince_d;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	// Offset reads move dataOut legally, so they are left out
	sequence s_rd_blocked;
		readClockEdge && !emptyFlag_n && (dualWriteMode || secondEnableOrLoadPin);
	endsequence
	a_reset_flags: assert property ($rose(rstn) |-> !emptyFlag_n && !almostEmptyFlag_n && almostFullFlag_n && fullFlag_n)
		else $error("flags not at reset levels");
	a_full_hold: assert property (!writeClockEdge |=> $stable({fullFlag_n, almostFullFlag_n}))
		else $error("full flags moved off a write edge");
	a_empty_hold: assert property (!readClockEdge |=> $stable({emptyFlag_n, almostEmptyFlag_n}))
		else $error("empty flags moved off a read edge");
	a_oe_drive: assert property (dataOutEn == !outputEnable_n)
		else $error("output drive does not follow enable");
	a_read_empty: assert property (s_rd_blocked |=> $stable(dataOut))
		else $error("read taken while empty");
	a_read_idle: assert property (!readClockEdge |=> $stable(dataOut))
		else $error("data changed without read edge");
	a_full_block: assert property (writeClockEdge && !fullFlag_n && !popSince_q && !popNow |=> !fullFlag_n)
		else $error("full flag cleared by a write");
	a_flag_order: assert property ((!fullFlag_n |-> !almostFullFlag_n) and (!emptyFlag_n |-> !almostEmptyFlag_n))
		else $error("almost flags disagree with full or empty");
endmodule : dcf_fifo_monitor

bind dcf_fifo dcf_fifo_monitor #(.DATA_W(DATA_W)) dcf_fifo_monitor_inst (.*);

// ---- tb/dcf_peer.sv ----
module dcf_peer (
	input wire logic  clk,
	input wire logic  rstn,
	input wire logic  wrReq,
	input wire logic  rdReq,
	input wire logic  fullFlag_n,
	input wire logic  secondEnableOrLoadPin,
	output logic       writeClockEdge,
	output logic       readClockEdge,
	output logic       primaryWriteEnable_n,
	output logic       readEnableA_n,
	output logic       readEnableB_n,
	output logic [8:0] dataIn
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] phase = 2'h0;
	logic       live = 1'b0;
	logic       taken = 1'b0;
	// Requests wait one cycle past reset release
	assign primaryWriteEnable_n = !(wrReq && live);
	assign readEnableA_n = !(rdReq && live);
	assign readEnableB_n = !(rdReq && live);
	// Writer only advances its count when the word was accepted
	always @(posedge clk) taken <= writeClockEdge && !primaryWriteEnable_n && fullFlag_n && secondEnableOrLoadPin;
	always @(negedge clk) begin
		phase <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
		writeClockEdge <= phase != 2'h0; // Two clocks out of step
		readClockEdge <= phase != 2'h1;
		live <= rstn;
		dataIn <= !rstn ? 9'h000 : dataIn + {8'h00, taken};
	end
endmodule : dcf_peer

// ---- tb/dcf_fifo_bench.sv ----
module dcf_fifo_bench;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {logic wr; logic rd; logic pin; dcf_pkg::dcf_flags_t flags;} dcf_row_t;
	// Fill to full, drain to empty, writes blocked by second enable
	localparam dcf_row_t ROWS [3] = '{7'h5c, 7'h33, 7'h43};
	logic clk, rstn, wrReq, rdReq, pin, oeN, pend;
	logic wce, rce, wenN, renA, renB, oe, empN, aeN, afN, fullN, dual;
	logic [8:0] dIn, dOut, expWord;
	dcf_pkg::dcf_flags_t flags;
	int nMismatch, testsRun;
	assign flags = {empN, aeN, afN, fullN};
	dcf_fifo #(.DEPTH(16), .ADDR_W(4)) dcf_fifo_inst (.clk(clk), .rstn(rstn), .writeClockEdge(wce),
		.readClockEdge(rce), .dataIn(dIn), .primaryWriteEnable_n(wenN), .secondEnableOrLoadPin(pin),
		.readEnableA_n(renA), .readEnableB_n(renB), .outputEnable_n(oeN), .dataOut(dOut), .dataOutEn(oe),
		.emptyFlag_n(empN), .almostEmptyFlag_n(aeN), .almostFullFlag_n(afN), .fullFlag_n(fullN),
		.dualWriteMode(dual));
	dcf_peer dcf_peer_inst (.clk(clk), .rstn(rstn), .wrReq(wrReq), .rdReq(rdReq), .fullFlag_n(fullN),
		.secondEnableOrLoadPin(pin), .writeClockEdge(wce), .readClockEdge(rce), .primaryWriteEnable_n(wenN),
		.readEnableA_n(renA), .readEnableB_n(renB), .dataIn(dIn));
	task check(input logic [8:0] seen, input logic [8:0] exp);
		testsRun++;
		if (seen !== exp) begin
			nMismatch++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task wrapUp;
		$display("checks %0d mismatches %0d", testsRun, nMismatch);
		if (nMismatch == 0 && testsRun > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : wrapUp
	task idle(input int n);
		repeat (n) @(negedge clk);
	endtask : idle
	// Stops right after the edge that takes the word numbered last
	task writeTo(input logic [8:0] last);
		wrReq <= 1'b1;
		for (int k = 0; k < 60; k++) begin
			@(posedge clk);
			if (dIn === last && wce && !wenN && fullN) break;
		end
		@(negedge clk);
		wrReq <= 1'b0;
	endtask : writeTo
	////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// Popped words must come back in write order
	always @(posedge clk) begin
		if (pend) check(dOut, expWord);
		if (pend) expWord = expWord + 9'h001;
		pend = rstn && rce && !renA && !renB && empN && (dual || pin);
		if (!rstn) expWord = 9'h000;
	end
	// Seven times the expected run
	initial begin
		#200000;
		nMismatch++;
		wrapUp();
	end
	initial begin
		rstn = 1'b0; wrReq = 1'b0; rdReq = 1'b0; pin = 1'b1; oeN = 1'b0;
		idle(4);
		rstn <= 1'b1;
		idle(2);
		check({5'h00, flags}, 9'h003);
		for (int i = 0; i < 3; i++) begin
			wrReq <= ROWS[i].wr; rdReq <= ROWS[i].rd; pin <= ROWS[i].pin;
			idle(60);
			check({5'h00, flags}, {5'h00, ROWS[i].flags});
			$display("row %0d done", i);
		end
		wrReq <= 1'b0; pin <= 1'b1;
		writeTo(9'h016);
		idle(6);
		check({7'h00, aeN, empN}, 9'h001);
		writeTo(9'h017);
		oeN <= 1'b1;
		idle(6);
		check({7'h00, aeN, oe}, 9'h002);
		oeN <= 1'b0; rdReq <= 1'b1;
		idle(30);
		rdReq <= 1'b0;
		$display("threshold test done");
		pin <= 1'b0; rstn <= 1'b0;
		idle(4);
		rstn <= 1'b1;
		idle(2);
		pin <= 1'b1;
		check({8'h00, dual}, 9'h000);
		writeTo(9'h003);
		rdReq <= 1'b1;
		idle(12);
		check({5'h00, flags}, 9'h003);
		$display("flag mode test done");
		rdReq <= 1'b0; pin <= 1'b0; wrReq <= 1'b1;
		idle(6);
		wrReq <= 1'b0; pin <= 1'b1;
		idle(1);
		writeTo(9'h008);
		idle(6);
		check({8'h00, aeN}, 9'h001);
		$display("offset load test done");
		wrapUp();
	end
endmodule : dcf_fifo_bench
